// *** hdl/hco_top.sv ***
// Hardware cursor overlay: indexed registers, sprite and crosshair merge
`timescale 1ns/100ps
module hco_top
  import hco_pkg::*;
(
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic [7:0] reg_index_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  input wire logic hsync_n_in,
  input wire logic vsync_n_in,
  input wire logic blank_n_in,
  input wire logic [PIX_W-1:0] pixel_in,
  output logic [PIX_W-1:0] pixel_out,
  output logic blank_n_out
);
  // Bank slot of every field, fixed once so each select stays five bits wide
  localparam logic [4:0] OFF_POS_XL = 5'(IDX_POS_XL - BANK_BASE);
  localparam logic [4:0] OFF_POS_XH = 5'(IDX_POS_XH - BANK_BASE);
  localparam logic [4:0] OFF_POS_YL = 5'(IDX_POS_YL - BANK_BASE);
  localparam logic [4:0] OFF_POS_YH = 5'(IDX_POS_YH - BANK_BASE);
  localparam logic [4:0] OFF_ORG_X = 5'(IDX_ORG_X - BANK_BASE);
  localparam logic [4:0] OFF_ORG_Y = 5'(IDX_ORG_Y - BANK_BASE);
  localparam logic [4:0] OFF_WS_XL = 5'(IDX_WS_XL - BANK_BASE);
  localparam logic [4:0] OFF_WS_YL = 5'(IDX_WS_YL - BANK_BASE);
  localparam logic [4:0] OFF_WE_XL = 5'(IDX_WE_XL - BANK_BASE);
  localparam logic [4:0] OFF_WE_YL = 5'(IDX_WE_YL - BANK_BASE);
  localparam logic [4:0] OFF_COL0 = 5'(IDX_COL0 - BANK_BASE);
  localparam logic [4:0] OFF_COL1 = 5'(IDX_COL1 - BANK_BASE);
  // High coordinate bytes and later color bytes sit in the following slots
  localparam logic [4:0] NEXT_SLOT = 5'h01;
  localparam logic [4:0] THIRD_SLOT = 5'h02;

  // Register state
  logic [7:0] ctrl;
  logic [RAM_AW-1:0] ram_addr;
  logic [7:0] bank [0:BANK_LEN-1];
  logic [7:0] rdata;
  logic [7:0] next_ctrl;
  logic [RAM_AW-1:0] next_ram_addr;
  logic [7:0] next_bank [0:BANK_LEN-1];
  logic [7:0] next_rdata;
  logic [7:0] host_rbyte;
  logic host_we;
  logic bank_hit;
  logic [7:0] bank_off;

  // Decoded settings
  logic [COORD_W-1:0] pos_x;
  logic [COORD_W-1:0] pos_y;
  logic [5:0] org_x;
  logic [5:0] org_y;
  logic [COORD_W-1:0] ws_x;
  logic [COORD_W-1:0] ws_y;
  logic [COORD_W-1:0] we_x;
  logic [COORD_W-1:0] we_y;
  logic [PIX_W-1:0] color0;
  logic [PIX_W-1:0] color1;

  // Raster and stage 0
  logic [COORD_W-1:0] rx;
  logic [COORD_W-1:0] ry;
  logic signed [13:0] dx;
  logic signed [13:0] dy;
  logic signed [13:0] cx;
  logic signed [13:0] cy;
  logic signed [13:0] half;
  logic in_spr;
  logic in_win;
  logic xh_hit;
  logic [RAM_AW-1:0] video_addr;
  logic [7:0] video_byte;

  // Pipeline stage 1 and outputs
  logic [PIX_W-1:0] pix1;
  logic blank1;
  logic spr1;
  logic xh1;
  logic [1:0] sel1;
  logic [PIX_W-1:0] next_pix1;
  logic next_blank1;
  logic next_spr1;
  logic next_xh1;
  logic [1:0] next_sel1;
  logic [PIX_W-1:0] pix_q;
  logic blank_q;
  logic [PIX_W-1:0] next_pix_q;
  logic next_blank_q;
  logic [1:0] code;
  hco_kind_t spr_kind;
  hco_kind_t xh_kind;
  hco_kind_t out_kind;

  hco_pattern_ram u_ram (
    .clock_in(clock_in),
    .host_we_in(host_we),
    .host_addr_in(ram_addr),
    .host_wdata_in(reg_wdata_in),
    .host_rdata_out(host_rbyte),
    .video_addr_in(video_addr),
    .video_rdata_out(video_byte)
  );

  hco_raster u_raster (
    .clock_in(clock_in),
    .nrst_in(nrst_in),
    .hsync_n_in(hsync_n_in),
    .vsync_n_in(vsync_n_in),
    .blank_n_in(blank_n_in),
    .x_out(rx),
    .y_out(ry)
  );

  // Bank covers positions, origin, window and colors; gap reads as zero
  assign bank_off = reg_index_in - BANK_BASE;
  assign bank_hit = (reg_index_in >= BANK_BASE && reg_index_in <= IDX_WIN_LAST) ||
                    (reg_index_in >= IDX_COL0 && reg_index_in <= IDX_COL_LAST);
  assign host_we = reg_wr_in && reg_index_in == IDX_RAM_DATA;

  // Register next values; a write wins if both strobes come together
  always_comb begin
    next_ctrl = ctrl;
    next_ram_addr = ram_addr;
    next_rdata = rdata;
    for (int i = 0; i < BANK_LEN; i++) begin
      next_bank[i] = bank[i];
    end
    if (reg_wr_in) begin
      unique case (reg_index_in)
        IDX_CTRL: next_ctrl = reg_wdata_in;
        IDX_ADDR_LO: next_ram_addr[7:0] = reg_wdata_in;
        IDX_ADDR_HI: next_ram_addr[RAM_AW-1:8] = reg_wdata_in[RAM_AW-9:0];
        IDX_RAM_DATA: next_ram_addr = ram_addr + 1'b1;
        default: begin
          if (bank_hit) begin
            next_bank[bank_off[4:0]] = reg_wdata_in;
          end
        end
      endcase
    end else if (reg_rd_in) begin
      unique case (reg_index_in)
        IDX_CTRL: next_rdata = ctrl;
        IDX_ADDR_LO: next_rdata = ram_addr[7:0];
        IDX_ADDR_HI: next_rdata = {{(16 - RAM_AW){1'b0}}, ram_addr[RAM_AW-1:8]};
        IDX_RAM_DATA: begin
          next_rdata = host_rbyte;
          next_ram_addr = ram_addr + 1'b1;
        end
        default: next_rdata = bank_hit ? bank[bank_off[4:0]] : 8'h00;
      endcase
    end
  end

  // Pattern address is cleared for a known start; memory itself is not
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctrl <= CTRL_RESET;
      ram_addr <= '0;
      rdata <= 8'h00;
      for (int i = 0; i < BANK_LEN; i++) begin
        bank[i] <= 8'h00;
      end
      bank[OFF_ORG_X] <= ORIGIN_RESET;
      bank[OFF_ORG_Y] <= ORIGIN_RESET;
    end else begin
      ctrl <= next_ctrl;
      ram_addr <= next_ram_addr;
      rdata <= next_rdata;
      for (int i = 0; i < BANK_LEN; i++) begin
        bank[i] <= next_bank[i];
      end
    end
  end

  // Field views of the bank
  assign pos_x = {bank[OFF_POS_XH][3:0], bank[OFF_POS_XL]};
  assign pos_y = {bank[OFF_POS_YH][3:0], bank[OFF_POS_YL]};
  assign org_x = bank[OFF_ORG_X][5:0];
  assign org_y = bank[OFF_ORG_Y][5:0];
  assign ws_x = {bank[OFF_WS_XL + NEXT_SLOT][3:0], bank[OFF_WS_XL]};
  assign ws_y = {bank[OFF_WS_YL + NEXT_SLOT][3:0], bank[OFF_WS_YL]};
  assign we_x = {bank[OFF_WE_XL + NEXT_SLOT][3:0], bank[OFF_WE_XL]};
  assign we_y = {bank[OFF_WE_YL + NEXT_SLOT][3:0], bank[OFF_WE_YL]};
  // Colors are stored red first, blue last
  assign color0 = {bank[OFF_COL0], bank[OFF_COL0 + NEXT_SLOT],
                   bank[OFF_COL0 + THIRD_SLOT]};
  assign color1 = {bank[OFF_COL1], bank[OFF_COL1 + NEXT_SLOT],
                   bank[OFF_COL1 + THIRD_SLOT]};

  // Array cell under this pixel: origin cell lands on cursor position
  assign dx = $signed({2'b00, rx}) + $signed({8'h00, org_x}) - $signed({2'b00, pos_x});
  assign dy = $signed({2'b00, ry}) + $signed({8'h00, org_y}) - $signed({2'b00, pos_y});
  assign in_spr = blank_n_in && !dx[13] && dx[12:6] == '0 &&
                  !dy[13] && dy[12:6] == '0;
  // Sixteen bytes per row, row zero at the top
  assign video_addr = {dy[5:0], dx[5:2]};

  // Crosshair bars: distance to position within half the thickness
  assign cx = $signed({2'b00, rx}) - $signed({2'b00, pos_x});
  assign cy = $signed({2'b00, ry}) - $signed({2'b00, pos_y});
  assign half = $signed({12'h000, ctrl[CTRL_THICK_LSB +: 2]});
  // A start beyond the active area is never reached, so nothing draws
  assign in_win = rx >= ws_x && rx <= we_x && ry >= ws_y && ry <= we_y;
  assign xh_hit = blank_n_in && in_win && ctrl[CTRL_XHAIR_SHOW] &&
                  ((cx >= -half && cx <= half) || (cy >= -half && cy <= half));

  // Stage 1 lines up with the one-cycle video read
  always_comb begin
    next_pix1 = pixel_in;
    next_blank1 = blank_n_in;
    next_spr1 = in_spr && ctrl[CTRL_SPRITE_EN];
    next_xh1 = xh_hit;
    next_sel1 = dx[1:0];
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pix1 <= '0;
      blank1 <= 1'b0;
      spr1 <= 1'b0;
      xh1 <= 1'b0;
      sel1 <= 2'b00;
    end else begin
      pix1 <= next_pix1;
      blank1 <= next_blank1;
      spr1 <= next_spr1;
      xh1 <= next_xh1;
      sel1 <= next_sel1;
    end
  end

  // Leftmost pixel of a byte sits in the top two bits
  always_comb begin
    unique case (sel1)
      2'b00: code = video_byte[7:6];
      2'b01: code = video_byte[5:4];
      2'b10: code = video_byte[3:2];
      2'b11: code = video_byte[1:0];
    endcase
  end

  // Pattern decode in the selected interpretation
  always_comb begin
    spr_kind = HCO_TRANSP;
    if (spr1) begin
      if (!ctrl[CTRL_MODE]) begin
        unique case (code)
          2'b00: spr_kind = HCO_COL0;
          2'b01: spr_kind = HCO_COL1;
          2'b10: spr_kind = HCO_TRANSP;
          2'b11: spr_kind = HCO_COMPL;
        endcase
      end else begin
        spr_kind = code[1] ? (code[0] ? HCO_COL1 : HCO_COL0) : HCO_TRANSP;
      end
    end
  end

  // Overlap resolution between crosshair and sprite
  always_comb begin
    xh_kind = ctrl[CTRL_XHAIR_COLOR] ? HCO_COL1 : HCO_COL0;
    out_kind = spr_kind;
    if (xh1) begin
      if (!ctrl[CTRL_OVERLAP] || spr_kind == HCO_TRANSP || spr_kind == HCO_COMPL) begin
        out_kind = xh_kind;
      end else if (spr_kind == HCO_COL0) begin
        out_kind = HCO_TRANSP;
      end else begin
        out_kind = HCO_COMPL;
      end
    end
  end

  // Output stage: blanked pixels pass untouched at the same latency
  always_comb begin
    next_blank_q = blank1;
    next_pix_q = pix1;
    if (blank1) begin
      unique case (out_kind)
        HCO_TRANSP: next_pix_q = pix1;
        HCO_COMPL: next_pix_q = ~pix1;
        HCO_COL0: next_pix_q = color0;
        HCO_COL1: next_pix_q = color1;
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pix_q <= '0;
      blank_q <= 1'b0;
    end else begin
      pix_q <= next_pix_q;
      blank_q <= next_blank_q;
    end
  end

  assign pixel_out = pix_q;
  assign blank_n_out = blank_q;
  assign reg_rdata_out = rdata;
endmodule : hco_top

// *** shared/hco_pkg.sv ***
// Constants, register indices and types for the hardware cursor overlay
// Functional notes
// - Sprite cursor is 64x64; two pattern bits used per pixel clock inside it.
// - Cursor logic assumes noninterlaced raster timing only.
// - X counts left to right, y top to bottom; (0,0) is first active pixel.
// - Control bits 1:0 pick crosshair thickness 1,3,5,7, centred on position.
// - Control bit 6 enables the sprite cursor.
// - Data port write stores one byte at pattern address, then increments it.
// - Data port read returns byte at pattern address, then increments it.
// - Pattern memory is not reset, always reachable, address zero is top-left.
// - Vertical retrace is seen as more than one sync inside one blank.
// - Control bit 4 picks pattern meaning: 0 first standard, 1 window standard.
// - Pattern decode per mode: colors, transparent and complement as tabled.
// - Sprite origin resets to (31,31); that cell sits at cursor position.
// - Origin spans (0,0) to (63,63); (0,0) puts array right and below.
// - Crosshair centres on cursor position, unaffected by sprite origin.
// - Control bit 2 shows crosshair; bit 3 selects its color.
// - Crosshair drawn only inside window start/stop region.
// - Crosshair window uses the shared auxiliary window register pair.
// - Overlap: bit 5 clear crosshair wins; set, sprite colors become see-through/complement.
package hco_pkg;
  localparam int COORD_W = 12;
  localparam int PIX_W = 24;
  localparam int RAM_AW = 10;
  localparam int RAM_DEPTH = 1024;
  localparam int BANK_LEN = 25;
  // Indexed register map
  localparam logic [7:0] IDX_CTRL = 8'h06;
  localparam logic [7:0] IDX_ADDR_LO = 8'h08;
  localparam logic [7:0] IDX_ADDR_HI = 8'h09;
  localparam logic [7:0] IDX_RAM_DATA = 8'h0A;
  localparam logic [7:0] BANK_BASE = 8'h10;
  localparam logic [7:0] IDX_POS_XL = 8'h10;
  localparam logic [7:0] IDX_POS_XH = 8'h11;
  localparam logic [7:0] IDX_POS_YL = 8'h12;
  localparam logic [7:0] IDX_POS_YH = 8'h13;
  localparam logic [7:0] IDX_ORG_X = 8'h14;
  localparam logic [7:0] IDX_ORG_Y = 8'h15;
  localparam logic [7:0] IDX_WS_XL = 8'h16;
  localparam logic [7:0] IDX_WS_YL = 8'h18;
  localparam logic [7:0] IDX_WE_XL = 8'h1A;
  localparam logic [7:0] IDX_WE_YL = 8'h1C;
  localparam logic [7:0] IDX_WIN_LAST = 8'h1D;
  localparam logic [7:0] IDX_COL0 = 8'h23;
  localparam logic [7:0] IDX_COL1 = 8'h26;
  localparam logic [7:0] IDX_COL_LAST = 8'h28;
  // Control register fields
  localparam int CTRL_THICK_LSB = 0;
  localparam int CTRL_XHAIR_SHOW = 2;
  localparam int CTRL_XHAIR_COLOR = 3;
  localparam int CTRL_MODE = 4;
  localparam int CTRL_OVERLAP = 5;
  localparam int CTRL_SPRITE_EN = 6;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] ORIGIN_RESET = 8'h1F;
  localparam logic [5:0] SPRITE_LAST = 6'h3F;
  // What one screen pixel shows
  typedef enum logic [1:0] {
    HCO_TRANSP = 2'b00,
    HCO_COMPL = 2'b01,
    HCO_COL0 = 2'b10,
    HCO_COL1 = 2'b11
  } hco_kind_t;
endpackage : hco_pkg

// *** hdl/hco_pattern_ram.sv ***
// Cursor pattern memory, 1024 bytes, host port and video read port
`timescale 1ns/100ps
module hco_pattern_ram
  import hco_pkg::*;
(
  input wire logic clock_in,
  input wire logic host_we_in,
  input wire logic [RAM_AW-1:0] host_addr_in,
  input wire logic [7:0] host_wdata_in,
  output logic [7:0] host_rdata_out,
  input wire logic [RAM_AW-1:0] video_addr_in,
  output logic [7:0] video_rdata_out
);
  // No reset: contents are undefined until software loads them
  logic [7:0] mem [0:RAM_DEPTH-1];

  // Host side write
  always_ff @(posedge clock_in) begin
    if (host_we_in) begin
      mem[host_addr_in] <= host_wdata_in;
    end
  end

  // Host read is direct so the data port answers in one cycle
  assign host_rdata_out = mem[host_addr_in];

  // Video read, one cycle latency, matched in the merge pipeline
  always_ff @(posedge clock_in) begin
    video_rdata_out <= mem[video_addr_in];
  end
endmodule : hco_pattern_ram

// *** hdl/hco_raster.sv ***
// Raster position tracker driven by active-low sync and blank
`timescale 1ns/100ps
module hco_raster
  import hco_pkg::*;
(
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic hsync_n_in,
  input wire logic vsync_n_in,
  input wire logic blank_n_in,
  output logic [COORD_W-1:0] x_out,
  output logic [COORD_W-1:0] y_out
);
  logic sync_q;
  logic seen;
  logic [COORD_W-1:0] x;
  logic [COORD_W-1:0] y;
  logic next_sync_q;
  logic next_seen;
  logic [COORD_W-1:0] next_x;
  logic [COORD_W-1:0] next_y;
  logic sync_any;
  logic sync_edge;

  // Either sync counts; progressive frames only, no field logic
  assign sync_any = ~(hsync_n_in & vsync_n_in);
  assign sync_edge = sync_any & ~sync_q;

  // First sync in blank steps a line, a second one marks vertical retrace
  always_comb begin
    next_sync_q = sync_any;
    next_seen = seen;
    next_y = y;
    next_x = x;
    if (blank_n_in) begin
      next_x = x + 1'b1;
      next_seen = 1'b0;
    end else begin
      next_x = '0;
      if (sync_edge) begin
        next_seen = 1'b1;
        if (seen) begin
          next_y = '0;
        end else begin
          next_y = y + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sync_q <= 1'b0;
      seen <= 1'b0;
      x <= '0;
      y <= '0;
    end else begin
      sync_q <= next_sync_q;
      seen <= next_seen;
      x <= next_x;
      y <= next_y;
    end
  end

  assign x_out = x;
  assign y_out = y;
endmodule : hco_raster

// *** bench/hco_checker_assertions.sv ***
// Port-level assertions for the hardware cursor overlay
`timescale 1ns/100ps
module hco_checker
  import hco_pkg::*;
(
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic [7:0] reg_index_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic blank_n_in,
  input wire logic [PIX_W-1:0] pixel_in,
  input wire logic [PIX_W-1:0] pixel_out,
  input wire logic blank_n_out
);
  logic [1:0] up_cnt;
  logic [1:0] next_up_cnt;
  logic [1:0] calm_cnt;
  logic [1:0] next_calm_cnt;
  logic [7:0] ctrl_q;
  logic [7:0] next_ctrl_q;
  // Control shadow; counters keep $past off reset-time samples
  always_comb begin
    next_up_cnt = (up_cnt == 2'h3) ? up_cnt : up_cnt + 2'h1;
    next_calm_cnt = (calm_cnt == 2'h3) ? calm_cnt : calm_cnt + 2'h1;
    next_ctrl_q = ctrl_q;
    if (reg_wr_in && reg_index_in == IDX_CTRL) begin
      next_calm_cnt = 2'h0;
      next_ctrl_q = reg_wdata_in;
    end
  end
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      up_cnt <= 2'h0;
      calm_cnt <= 2'h0;
      ctrl_q <= CTRL_RESET;
    end else begin
      up_cnt <= next_up_cnt;
      calm_cnt <= next_calm_cnt;
      ctrl_q <= next_ctrl_q;
    end
  end
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  sequence s_rd(idx); reg_rd_in && !reg_wr_in && reg_index_in == idx; endsequence
  sequence s_wr(idx); reg_wr_in && reg_index_in == idx; endsequence
  property p_blank_delay; up_cnt == 2'h3 |-> blank_n_out == $past(blank_n_in, 2); endproperty
  a_blank_delay: assert property (p_blank_delay) else $error("blank delay wrong");
  property p_blank_pass;
    up_cnt == 2'h3 && !$past(blank_n_in, 2) |-> pixel_out == $past(pixel_in, 2);
  endproperty
  a_blank_pass: assert property (p_blank_pass) else $error("pixel altered in blank");
  property p_rd_hold; !(reg_rd_in && !reg_wr_in) |=> $stable(reg_rdata_out); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_unmapped; s_rd(8'hFF) |=> reg_rdata_out == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_ctrl_rd; s_rd(IDX_CTRL) |=> reg_rdata_out == ctrl_q; endproperty
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("control readback wrong");
  property p_hi_rd; s_rd(IDX_ADDR_HI) |=> reg_rdata_out[7:2] == 6'h00; endproperty
  a_hi_rd: assert property (p_hi_rd) else $error("address high bits set");
  property p_no_cursor;
    up_cnt == 2'h3 && calm_cnt == 2'h3 && !ctrl_q[CTRL_XHAIR_SHOW] && !ctrl_q[CTRL_SPRITE_EN]
      |-> pixel_out == $past(pixel_in, 2);
  endproperty
  a_no_cursor: assert property (p_no_cursor) else $error("pixel altered, cursors off");
  property p_addr_step;
    s_wr(IDX_ADDR_LO) ##0 reg_wdata_in != 8'hFF ##1 s_wr(IDX_ADDR_HI) ##1
      s_wr(IDX_RAM_DATA) ##1 s_rd(IDX_ADDR_LO) |=> reg_rdata_out == $past(reg_wdata_in, 4) + 8'h01;
  endproperty
  a_addr_step: assert property (p_addr_step) else $error("address did not step");
endmodule : hco_checker
bind hco_top hco_checker i_chk (.clock_in(clock_in), .nrst_in(nrst_in),
  .reg_index_in(reg_index_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .blank_n_in(blank_n_in),
  .pixel_in(pixel_in), .pixel_out(pixel_out), .blank_n_out(blank_n_out));

// *** bench/hco_video_src.sv ***
// Video source model: active-low syncs, blank and a pixel ramp
`timescale 1ns/100ps
module hco_video_src
  import hco_pkg::*;
#(
  parameter int ACT = 100,
  parameter int LINE = 220,
  parameter int NL = 8
)
(
  input wire logic clock_in,
  input wire logic nrst_in,
  output logic hsync_n_out,
  output logic vsync_n_out,
  output logic blank_n_out,
  output logic [PIX_W-1:0] pixel_out,
  output logic [7:0] x_out,
  output logic [7:0] y_out
);
  int cnt;
  int line;
  // Counters move on the falling edge, clear of the sampling edge
  always @(negedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt <= 0;
      line <= 0;
    end else if (cnt == LINE - 1) begin
      cnt <= 0;
      line <= (line == NL - 1) ? 0 : line + 1;
    end else begin
      cnt <= cnt + 1;
    end
  end
  // Second sync only in the last blank; back porch left at 92 clocks
  always_comb begin
    blank_n_out = cnt < ACT;
    hsync_n_out = !(cnt >= ACT + 2 && cnt < ACT + 10);
    vsync_n_out = !(line == NL - 1 && cnt >= ACT + 20 && cnt < ACT + 28);
    x_out = 8'(cnt);
    y_out = 8'(line);
    pixel_out = blank_n_out ? {8'hC3, y_out, x_out} : {y_out, 8'(cnt), 8'h5A};
  end
endmodule : hco_video_src

// *** bench/tb_top.sv ***
// Self-checking bench for the hardware cursor overlay
`timescale 1ns/100ps
module tb_top
  import hco_pkg::*;
;
  localparam logic [PIX_W-1:0] C0 = 24'h112233;
  localparam logic [PIX_W-1:0] C1 = 24'h445566;
  logic clock_in = 1'b0;
  logic nrst_in = 1'b0;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [7:0] reg_index_in = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic [7:0] reg_rdata_out, vx, vy;
  logic hsync_n_in, vsync_n_in, blank_n_in, blank_n_out;
  logic [PIX_W-1:0] pixel_in, pixel_out;
  int num_errors = 0;
  int total_checks = 0;
  initial forever #2.5 clock_in = ~clock_in;
  hco_top i_dut (.clock_in(clock_in), .nrst_in(nrst_in), .reg_index_in(reg_index_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .hsync_n_in(hsync_n_in), .vsync_n_in(vsync_n_in),
    .blank_n_in(blank_n_in), .pixel_in(pixel_in), .pixel_out(pixel_out),
    .blank_n_out(blank_n_out));
  hco_video_src i_src (.clock_in(clock_in), .nrst_in(nrst_in), .hsync_n_out(hsync_n_in),
    .vsync_n_out(vsync_n_in), .blank_n_out(blank_n_in), .pixel_out(pixel_in),
    .x_out(vx), .y_out(vy));
  task automatic results();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results
  task automatic chk(input logic [PIX_W-1:0] seen, input logic [PIX_W-1:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Strobe left high so writes can run back to back
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    @(negedge clock_in);
    reg_rd_in = 1'b0;
    reg_wr_in = 1'b1;
    reg_index_in = idx;
    reg_wdata_in = d;
  endtask : wr
  task automatic idle();
    @(negedge clock_in);
    reg_wr_in = 1'b0;
  endtask : idle
  task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
    @(negedge clock_in);
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b1;
    reg_index_in = idx;
    @(negedge clock_in);
    reg_rd_in = 1'b0;
    chk({16'h0000, reg_rdata_out}, {16'h0000, exp});
  endtask : rchk
  // Catch pixel (x,y) at the source, judge the merged pixel two edges later
  task automatic look(input int x, input int y, input hco_kind_t k);
    logic [PIX_W-1:0] p;
    int n;
    n = 0;
    do begin
      @(posedge clock_in);
      n++;
    end while (!(blank_n_in && vx == x && vy == y) && n < 2000);
    if (n >= 2000) begin
      chk(24'h000000, 24'hFFFFFF);
      results();
    end
    p = pixel_in;
    // Merged pixel stands between the next edge and the one after it
    @(posedge clock_in);
    @(negedge clock_in);
    chk({23'h000000, blank_n_out}, 24'h000001);
    chk(pixel_out, k == HCO_TRANSP ? p : k == HCO_COMPL ? ~p : k == HCO_COL0 ? C0 : C1);
  endtask : look
  task automatic t_regs();
    rchk(IDX_CTRL, CTRL_RESET);
    rchk(IDX_ORG_X, ORIGIN_RESET);
    rchk(IDX_ORG_Y, ORIGIN_RESET);
    wr(IDX_CTRL, 8'h7F);
    rchk(IDX_CTRL, 8'h7F);
    wr(IDX_ADDR_HI, 8'hFF);
    rchk(IDX_ADDR_HI, 8'h03);
    rchk(8'hFF, 8'h00);
    for (int i = 0; i < 3; i++) begin
      wr(IDX_COL0 + 8'(i), C0[8*(2-i) +: 8]);
      wr(IDX_COL1 + 8'(i), C1[8*(2-i) +: 8]);
    end
  endtask : t_regs
  // Sprite held off while the pattern memory is touched
  task automatic t_ram();
    wr(IDX_CTRL, 8'h00);
    wr(IDX_ADDR_LO, 8'hFE);
    wr(IDX_ADDR_HI, 8'h03);
    wr(IDX_RAM_DATA, 8'hA5);
    rchk(IDX_ADDR_LO, 8'hFF);
    wr(IDX_RAM_DATA, 8'h3C);
    wr(IDX_RAM_DATA, 8'h96);
    rchk(IDX_ADDR_LO, 8'h01);
    rchk(IDX_ADDR_HI, 8'h00);
    wr(IDX_ADDR_LO, 8'hFE);
    wr(IDX_ADDR_HI, 8'h03);
    rchk(IDX_RAM_DATA, 8'hA5);
    rchk(IDX_RAM_DATA, 8'h3C);
    rchk(IDX_RAM_DATA, 8'h96);
  endtask : t_ram
  task automatic t_sprite();
    wr(IDX_ADDR_LO, 8'h00);
    wr(IDX_ADDR_HI, 8'h00);
    wr(IDX_RAM_DATA, 8'h1B);
    wr(IDX_ORG_X, 8'h00);
    wr(IDX_ORG_Y, 8'h00);
    wr(IDX_POS_XL, 8'h0A);
    wr(IDX_POS_YL, 8'h01);
    for (int m = 0; m < 2; m++) begin
      wr(IDX_CTRL, m ? 8'h50 : 8'h40);
      idle();
      look(10, 1, m ? HCO_TRANSP : HCO_COL0);
      look(11, 1, m ? HCO_TRANSP : HCO_COL1);
      look(12, 1, m ? HCO_COL0 : HCO_TRANSP);
      look(13, 1, m ? HCO_COL1 : HCO_COMPL);
      look(9, 1, HCO_TRANSP);
      look(10, 0, HCO_TRANSP);
    end
  endtask : t_sprite
  task automatic t_xhair();
    wr(IDX_WE_XL, 8'h63);
    wr(IDX_WE_YL, 8'h07);
    wr(IDX_POS_XL, 8'h14);
    wr(IDX_POS_YL, 8'h02);
    // Line 6 lies beyond the widest horizontal bar around row 2
    for (int t = 0; t < 4; t++) begin
      wr(IDX_CTRL, 8'h04 | 8'(t));
      idle();
      look(20 + t, 6, HCO_COL0);
      look(21 + t, 6, HCO_TRANSP);
    end
    wr(IDX_CTRL, 8'h0C);
    idle();
    look(20, 3, HCO_COL1);
    wr(IDX_CTRL, 8'h08);
    idle();
    look(20, 3, HCO_TRANSP);
    wr(IDX_WS_XL, 8'h0F);
    wr(IDX_WE_XL, 8'h19);
    wr(IDX_CTRL, 8'h04);
    idle();
    look(14, 2, HCO_TRANSP);
    look(15, 2, HCO_COL0);
    look(25, 2, HCO_COL0);
    look(26, 2, HCO_TRANSP);
  endtask : t_xhair
  task automatic t_over();
    wr(IDX_WS_XL, 8'h00);
    wr(IDX_WE_XL, 8'h63);
    wr(IDX_POS_XL, 8'h0A);
    wr(IDX_POS_YL, 8'h01);
    wr(IDX_CTRL, 8'h4C);
    idle();
    look(10, 1, HCO_COL1);
    look(11, 1, HCO_COL1);
    wr(IDX_CTRL, 8'h6C);
    idle();
    look(10, 1, HCO_TRANSP);
    look(11, 1, HCO_COMPL);
    look(12, 1, HCO_COL1);
    look(13, 1, HCO_COL1);
  endtask : t_over
  // Reset held for eight clocks, released off the sampling edge
  initial begin
    repeat (8) @(posedge clock_in);
    @(negedge clock_in);
    nrst_in = 1'b1;
    t_regs();
    t_ram();
    t_sprite();
    t_xhair();
    t_over();
    results();
  end
endmodule : tb_top
